// ---- logic/twsd_pkg.sv ----
// Purpose: constants shared by the two-wire status and data register block
// Assumes: 8-bit I/O register port, status code held as five bits
// Notes: status codes are the upper five bits of the full status byte
package twsd_pkg;

  // ==========================================================
  // register offsets and layout
  localparam logic [5:0] IO_STATUS = 6'h01;
  localparam logic [5:0] IO_DATA = 6'h03;
  localparam int STATUS_LSB = 3;
  localparam int PSEL_LSB = 0;
  localparam logic [7:0] STATUS_RESET = 8'hf8;
  localparam logic [7:0] DATA_RESET = 8'hff;

  // ==========================================================
  // status codes, five bits each
  localparam logic [4:0] ST_IDLE = 5'h1f;
  localparam logic [4:0] ST_START = 5'h01;
  localparam logic [4:0] ST_TX_ACK = 5'h05;
  localparam logic [4:0] ST_TX_NACK = 5'h06;
  localparam logic [4:0] ST_ARB_LOST = 5'h07;
  localparam logic [4:0] ST_RX_ACK = 5'h0a;
  localparam logic [4:0] ST_RX_NACK = 5'h0b;

  // ==========================================================
  // timing
  localparam logic [7:0] RATE_BASE = 8'h02;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // prescale select to divide factor
  function automatic logic [7:0] twsd_psc_val(input logic [1:0] sel);
    case (sel)
      2'h0: twsd_psc_val = 8'h01;
      2'h1: twsd_psc_val = 8'h04;
      2'h2: twsd_psc_val = 8'h10;
      default: twsd_psc_val = 8'h40;
    endcase
  endfunction

endpackage

// ---- logic/twsd_rate_if.sv ----
// Purpose: carries prescale select and bit tick between engine and divider
// Assumes: both ends on the link clock
// Notes: none
`timescale 1ns/1ps
interface twsd_rate_if;
  logic [1:0] psel;
  logic tick;
  modport gen (input psel, output tick);
  modport user (output psel, input tick);
endinterface

// ---- logic/twsd_sync.sv ----
// Purpose: two-flop synchroniser for levels and toggles
// Assumes: each bit crosses independently or is quasi-static
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module twsd_sync #(
  parameter int W = 1
) (
  input wire logic clk, // destination clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous input
  output logic [W-1:0] q // synchronised output
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // twsd_sync

// ---- logic/twsd_rate_gen.sv ----
// Purpose: bit-rate tick generator scaled by the prescale select
// Assumes: runs on the link clock
// Notes: one tick pulse every prescale*base link cycles
`timescale 1ns/1ps
module twsd_rate_gen (
  input wire logic clk_link, // link clock
  input wire logic rstl_n, // link reset, active low
  twsd_rate_if.gen r // prescale select in, tick out
);
  import twsd_pkg::*;
  logic [7:0] cnt_q;
  logic tick_q;
  logic [7:0] lim;
  logic at_lim;

  assign lim = twsd_psc_val(r.psel) * RATE_BASE - 8'h01;
  assign at_lim = (cnt_q >= lim);
  assign r.tick = tick_q;

  always_ff @(posedge clk_link or negedge rstl_n) begin
    if (!rstl_n) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= at_lim ? 8'h00 : cnt_q + 8'h01;
      tick_q <= at_lim;
    end
  end
endmodule // twsd_rate_gen

// ---- logic/twsd_top.sv ----
// Purpose: status/prescaler and data byte registers of a two-wire port
// Assumes: registers reached over the 6-bit I/O port; link on clk_link
// Notes: pins are open drain, enable high pulls the line low
// Function
// - status register bits 7:3 show a read-only five-bit status code
// - status bits 1:0 read/write, select prescale 1, 4, 16 or 64
// - bit-rate generator divides by twice the selected prescale value (prescale * RATE_BASE)
// - data register holds next byte to send or last byte received
// - data register writable only while completion flag is set
// - data register unchanged by hardware while completion flag stays set
// - byte shifted in while shifted out; register holds last bus byte
// - after wake by own interrupt the data contents are undefined
// - on lost arbitration the received byte is kept, none lost
// - acknowledge bit handled by logic, not reachable by software
// - registers at I/O offsets within 0x00-0x3f, data space plus 0x20
// - writing one clears the flag; no operation while set, start after
`timescale 1ns/1ps
module twsd_top (
  input wire logic clk, // system clock, 25 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [5:0] io_addr, // I/O register offset
  input wire logic io_wr, // write strobe
  input wire logic io_rd, // read strobe
  input wire logic [7:0] io_wdata, // write data
  output logic [7:0] io_rdata, // read data, registered
  input wire logic flag_clear, // software wrote one to the flag
  input wire logic start_sent, // start condition done, sets the flag
  input wire logic go_rx, // next byte is received, not sent
  input wire logic ack_enable, // acknowledge received bytes
  input wire logic asleep, // woken from sleep by the port interrupt
  output logic step_done_flag, // completion flag
  input wire logic clk_link, // link clock
  input wire logic scl_in, // clock pin level
  output logic scl_out, // clock pin drive value
  output logic scl_oe, // clock pin pull low
  input wire logic sda_in, // data pin level
  output logic sda_out, // data pin drive value
  output logic sda_oe // data pin pull low
);
  import twsd_pkg::*;

  typedef enum logic [1:0] {L_IDLE, L_LOW, L_HIGH} twsd_lstate_t;

  // ==========================================================
  // core side registers
  logic [4:0] status_q, status_d;
  logic [1:0] psel_q;
  logic [7:0] buf_q, rdata_q, tx_hold_q;
  logic flag_q, busy_q, start_tgl_q, rx_mode_q, ack_en_q;
  logic done_s, done_ed_q;
  logic sel_status, sel_data, wr_status, wr_data, go, done_c;
  logic load_rx;
  logic [7:0] rd_mux;

  // link side registers
  twsd_lstate_t lst_q, lst_d;
  logic [1:0] rstl_q;
  logic rstl_n;
  logic start_s, start_ed_q, lgo;
  logic [1:0] pins_s;
  logic scl_s, sda_s;
  logic [3:0] bcnt_q, bcnt_d;
  logic [7:0] sh_q, sh_d;
  logic lost_q, lost_d, ackseen_q, ackseen_d;
  logic done_tgl_q, done_tgl_d, scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic drive_bit, is_ack_slot, arb_hit;
  logic [1:0] psel_l;

  twsd_rate_if rif ();

  // ==========================================================
  // register decode
  assign sel_status = (io_addr == IO_STATUS);
  assign sel_data = (io_addr == IO_DATA);
  assign wr_status = io_wr & sel_status;
  assign wr_data = io_wr & sel_data & flag_q;
  // bit 2 and the ack bit have no place on the bus
  assign rd_mux = sel_status ? {status_q, 1'b0, psel_q}
                : sel_data ? buf_q : 8'h00;
  assign io_rdata = rdata_q;
  assign step_done_flag = flag_q;

  // ==========================================================
  // completion flag and sequencing
  assign go = flag_clear & flag_q & ~busy_q;
  assign done_c = done_s ^ done_ed_q;
  // after a sleep wake the shifter content is not trusted
  assign load_rx = done_c & ~asleep;

  always_comb begin
    status_d = status_q;
    if (done_c) begin
      if (lost_q)
        status_d = ST_ARB_LOST;
      else if (rx_mode_q)
        status_d = ackseen_q ? ST_RX_ACK : ST_RX_NACK;
      else
        status_d = ackseen_q ? ST_TX_ACK : ST_TX_NACK;
    end else if (start_sent) begin
      status_d = ST_START;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      busy_q <= 1'b0;
      status_q <= STATUS_RESET[7:STATUS_LSB];
      psel_q <= STATUS_RESET[PSEL_LSB+1:PSEL_LSB];
    end else begin
      // a setting event wins over a same-cycle clear
      flag_q <= (flag_q & ~go) | done_c | start_sent;
      busy_q <= (busy_q & ~done_c) | go;
      status_q <= status_d;
      if (wr_status)
        psel_q <= io_wdata[PSEL_LSB+1:PSEL_LSB];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_q <= DATA_RESET;
      rdata_q <= 8'h00;
    end else begin
      if (load_rx)
        buf_q <= sh_q;
      else if (wr_data)
        buf_q <= io_wdata;
      if (io_rd)
        rdata_q <= rd_mux;
    end
  end

  // held stable for the link while busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_tgl_q <= 1'b0;
      tx_hold_q <= 8'h00;
      rx_mode_q <= 1'b0;
      ack_en_q <= 1'b0;
      done_ed_q <= 1'b0;
    end else begin
      done_ed_q <= done_s;
      if (go) begin
        start_tgl_q <= ~start_tgl_q;
        tx_hold_q <= buf_q;
        rx_mode_q <= go_rx;
        ack_en_q <= ack_enable;
      end
    end
  end

  twsd_sync #(.W(1)) u_done_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(done_tgl_q),
    .q(done_s)
  );

  // ==========================================================
  // link domain reset, released on the link clock
  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n)
      rstl_q <= 2'b00;
    else
      rstl_q <= {rstl_q[0], 1'b1};
  end
  assign rstl_n = rstl_q[1];

  twsd_sync #(.W(1)) u_start_sync (
    .clk(clk_link),
    .rst_n(rstl_n),
    .d(start_tgl_q),
    .q(start_s)
  );

  twsd_sync #(.W(2)) u_pin_sync (
    .clk(clk_link),
    .rst_n(rstl_n),
    .d({scl_in, sda_in}),
    .q(pins_s)
  );

  // quasi-static: software changes it only between bytes
  twsd_sync #(.W(2)) u_psel_sync (
    .clk(clk_link),
    .rst_n(rstl_n),
    .d(psel_q),
    .q(psel_l)
  );

  assign rif.psel = psel_l;

  twsd_rate_gen u_rate (
    .clk_link(clk_link),
    .rstl_n(rstl_n),
    .r(rif.gen)
  );

  // ==========================================================
  // byte engine on the link clock
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  assign lgo = start_s ^ start_ed_q;
  assign is_ack_slot = (bcnt_q == ACK_SLOT);
  // acknowledge is ours to drive only when receiving
  assign drive_bit = is_ack_slot ? (rx_mode_q & ack_en_q)
                   : (~rx_mode_q & ~lost_q & ~sh_q[7]);
  // released a one but the line reads low: another master won
  assign arb_hit = ~rx_mode_q & ~lost_q & sh_q[7] & ~sda_s;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;

  always_comb begin
    lst_d = lst_q;
    bcnt_d = bcnt_q;
    sh_d = sh_q;
    lost_d = lost_q;
    ackseen_d = ackseen_q;
    done_tgl_d = done_tgl_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    case (lst_q)
      L_IDLE: begin
        if (lgo) begin
          lst_d = L_LOW;
          bcnt_d = 4'h0;
          sh_d = tx_hold_q;
          lost_d = 1'b0;
          scl_oe_d = 1'b1;
        end
      end
      L_LOW: begin
        scl_oe_d = 1'b1;
        sda_oe_d = drive_bit;
        if (rif.tick) begin
          lst_d = L_HIGH;
          scl_oe_d = 1'b0;
        end
      end
      L_HIGH: begin
        // waiting on scl_s lets a slow partner stretch the clock
        if (rif.tick & scl_s) begin
          scl_oe_d = 1'b1;
          if (!is_ack_slot) begin
            sh_d = {sh_q[6:0], sda_s};
            if (arb_hit)
              lost_d = 1'b1;
            bcnt_d = bcnt_q + 4'h1;
            lst_d = L_LOW;
          end else begin
            ackseen_d = rx_mode_q ? ack_en_q : ~sda_s;
            sda_oe_d = 1'b0;
            done_tgl_d = ~done_tgl_q;
            lst_d = L_IDLE;
          end
        end
      end
      default: lst_d = L_IDLE;
    endcase
  end

  // after a byte, scl stays pulled low in idle until the flag is cleared
  always_ff @(posedge clk_link or negedge rstl_n) begin
    if (!rstl_n) begin
      lst_q <= L_IDLE;
      start_ed_q <= 1'b0;
      bcnt_q <= 4'h0;
      sh_q <= 8'h00;
      lost_q <= 1'b0;
      ackseen_q <= 1'b0;
      done_tgl_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      lst_q <= lst_d;
      start_ed_q <= start_s;
      bcnt_q <= bcnt_d;
      sh_q <= sh_d;
      lost_q <= lost_d;
      ackseen_q <= ackseen_d;
      done_tgl_q <= done_tgl_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  // ==========================================================
  // checks, core domain
  sequence s_clear_taken;
    flag_q && flag_clear && !busy_q;
  endsequence

  sequence s_running;
    !flag_q && busy_q;
  endsequence

  a_status_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    io_rd && sel_status |=>
    io_rdata == {$past(status_q), 1'b0, $past(psel_q)})
    else $error("status read does not show code and prescale");
  a_psel_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_status |=> psel_q == $past(io_wdata[1:0]))
    else $error("prescale select not written");
  a_bit2_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(io_rd) && $past(sel_status) |-> io_rdata[2] == 1'b0)
    else $error("status bit 2 not zero");
  a_buf_locked: assert property (
    @(posedge clk) disable iff (!rst_n)
    io_wr && sel_data && !flag_q && !done_c |=> $stable(buf_q))
    else $error("data register written while flag clear");
  a_buf_steady: assert property (
    @(posedge clk) disable iff (!rst_n)
    flag_q && !(io_wr && sel_data) |=> $stable(buf_q))
    else $error("data register changed while flag set");
  a_clear_starts: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_clear_taken |=> s_running and start_tgl_q != $past(start_tgl_q))
    else $error("cleared flag did not start the byte");
  a_no_start_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    flag_q && !flag_clear |=> $stable(start_tgl_q))
    else $error("operation started while flag set");
  a_done_loads: assert property (
    @(posedge clk) disable iff (!rst_n)
    done_c && !asleep |=> flag_q && buf_q == $past(sh_q) && !busy_q)
    else $error("received byte not loaded at completion");
  a_sleep_keeps: assert property (
    @(posedge clk) disable iff (!rst_n)
    done_c && asleep |=> flag_q && $stable(buf_q))
    else $error("data register loaded after sleep wake");
  a_arb_keeps: assert property (
    @(posedge clk) disable iff (!rst_n)
    done_c && lost_q |=> status_q == ST_ARB_LOST && flag_q)
    else $error("arbitration loss not reported");
  a_unmapped_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    io_rd && !sel_status && !sel_data |=> io_rdata == 8'h00)
    else $error("unmapped offset read not zero");

  // checks, link domain
  a_scl_released: assert property (
    @(posedge clk_link) disable iff (!rstl_n)
    lst_q == L_LOW && rif.tick |=> lst_q == L_HIGH && !scl_oe_q)
    else $error("clock not released on tick");

  a_ack_driven: assert property (
    @(posedge clk_link) disable iff (!rstl_n)
    lst_q == L_LOW && is_ack_slot && rx_mode_q && ack_en_q |=> sda_oe_q)
    else $error("acknowledge not driven");

endmodule // twsd_top

// ---- verification/twsd_bus_model.sv ----
// Purpose: far-side bus party on the two wires, sends or samples bytes
// Assumes: lines have pull-ups; model only ever pulls the data line
// Notes: bit count restarts on frame_rst, given while the clock line is idle before each byte
`timescale 1ns/1ps
module twsd_bus_model (
  input wire logic scl, // clock line level
  input wire logic sda, // data line level
  input wire logic frame_rst, // restart bit count
  input wire logic send_mode, // model shifts a byte out
  input wire logic [7:0] tx_byte, // byte the model sends
  input wire logic ack_low, // model acknowledges bytes it receives
  output logic sda_pull, // model pulls data line low
  output logic [7:0] seen // byte sampled on the wire
);
  int cnt;
  initial begin
    cnt = 0;
    sda_pull = 1'b0;
    seen = 8'h00;
  end
  // ==========================================================
  // sample on rising clock, msb first
  always @(posedge scl) begin
    if (cnt < 8) seen <= {seen[6:0], sda};
    cnt <= cnt + 1;
  end
  // ==========================================================
  // change data only while clock is low
  always @(negedge scl, posedge frame_rst) begin
    if (frame_rst) cnt = 0;
    if (send_mode && cnt < 8) sda_pull = ~tx_byte[7-cnt];
    else if (!send_mode && cnt == 8) sda_pull = ack_low;
    else sda_pull = 1'b0; // released, pull-up wins
  end
endmodule // twsd_bus_model

// ---- verification/twsd_top_tb.sv ----
// Purpose: self-checking bench for the status and data byte registers
// Assumes: inputs driven at falling clk edge; open-drain wires pulled up
// Notes: expected timing reckoned from prescale and a two-tick bit
`timescale 1ns/1ps
module twsd_top_tb;
  import twsd_pkg::*;
  logic clk, rst_n, clk_link, io_wr, io_rd, flag_clear, start_sent;
  logic go_rx, ack_enable, asleep, step_done_flag;
  logic scl_out, scl_oe, sda_out, sda_oe, sda_pull;
  logic frame_rst, send_mode, ack_low;
  logic [5:0] io_addr;
  logic [7:0] io_wdata, io_rdata, tx_byte, seen, rd_v;
  wire scl_w = ~scl_oe;
  wire sda_w = ~(sda_oe | sda_pull);
  int mismatches, cmp_count, cyc, p;

  twsd_top twsd_top_inst (.clk(clk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .flag_clear(flag_clear), .start_sent(start_sent),
    .go_rx(go_rx), .ack_enable(ack_enable), .asleep(asleep),
    .step_done_flag(step_done_flag), .clk_link(clk_link), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe));
  twsd_bus_model twsd_bus_model_inst (.scl(scl_w), .sda(sda_w),
    .frame_rst(frame_rst), .send_mode(send_mode), .tx_byte(tx_byte),
    .ack_low(ack_low), .sda_pull(sda_pull), .seen(seen));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // link clock offset so edges never line up
  initial begin
    clk_link = 1'b0;
    #3;
    forever #6 clk_link = ~clk_link;
  end
  // ==========================================================
  // compare and access tasks
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
  endtask
  task automatic chk(input logic [5:0] a, input logic [7:0] exp);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    rd_v = io_rdata;
    cmp8(rd_v, exp);
  endtask
  task automatic clear_flag;
    @(negedge clk);
    flag_clear = 1'b1;
    @(negedge clk);
    flag_clear = 1'b0;
  endtask
  task automatic run_op(input logic rx, input logic ack, input logic ps,
                        input logic pa, input logic [7:0] pb);
    go_rx = rx;
    ack_enable = ack;
    send_mode = ps;
    ack_low = pa;
    tx_byte = pb;
    @(negedge clk);
    frame_rst = 1'b1;
    @(negedge clk);
    frame_rst = 1'b0;
    clear_flag();
    cmp1(step_done_flag, 1'b0);
    wr(IO_DATA, 8'h00);
    cyc = 3;
    while (step_done_flag !== 1'b1 && cyc < 3000) begin
      @(negedge clk);
      cyc++;
    end
    // a byte that never completes counts here as a mismatch
    cmp1(step_done_flag, 1'b1);
  endtask
  task automatic final_report;
    $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {rst_n, io_wr, io_rd, flag_clear, start_sent, go_rx} = 6'h00;
    {ack_enable, asleep, frame_rst, send_mode, ack_low} = 5'h00;
    io_addr = 6'h00;
    io_wdata = 8'h00;
    tx_byte = 8'h00;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    chk(IO_STATUS, STATUS_RESET);
    cmp1(scl_oe | sda_oe, 1'b0);
    cmp1(scl_out | sda_out, 1'b0);
    chk(IO_DATA, DATA_RESET);
    wr(IO_DATA, 8'h55);
    chk(IO_DATA, DATA_RESET);
    clear_flag();
    cmp1(step_done_flag, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(IO_STATUS, 8'h04 | i[7:0]);
      chk(IO_STATUS, {ST_IDLE, 1'b0, i[1:0]});
    end
    wr(6'h02, 8'h12);
    chk(6'h02, 8'h00);
    chk(IO_DATA, DATA_RESET);
    $display("test registers done");
    @(negedge clk);
    start_sent = 1'b1;
    @(negedge clk);
    start_sent = 1'b0;
    cmp1(step_done_flag, 1'b1);
    chk(IO_STATUS, {ST_START, 3'h3});
    for (int i = 0; i < 4; i++) begin
      p = 1 << (2 * i);
      wr(IO_STATUS, i[7:0]);
      wr(IO_DATA, 8'ha5 ^ i[7:0]);
      chk(IO_DATA, 8'ha5 ^ i[7:0]);
      run_op(1'b0, 1'b0, 1'b0, ~i[0], 8'h00);
      cmp_rng(cyc, (384 * p) / 40 - 4, (480 * p) / 40 + 24);
      cmp8(seen, 8'ha5 ^ i[7:0]);
      chk(IO_STATUS,
          {i[0] ? ST_TX_NACK : ST_TX_ACK, 1'b0, i[1:0]});
      cmp8(rd_v & 8'hf8, {i[0] ? ST_TX_NACK : ST_TX_ACK, 3'h0});
      repeat (20) @(negedge clk);
      chk(IO_DATA, 8'ha5 ^ i[7:0]);
    end
    $display("test send done");
    wr(IO_STATUS, 8'h00);
    for (int j = 0; j < 2; j++) begin
      run_op(1'b1, ~j[0], 1'b1, 1'b0, 8'h3c ^ j[7:0]);
      chk(IO_STATUS, {j[0] ? ST_RX_NACK : ST_RX_ACK, 3'h0});
      chk(IO_DATA, 8'h3c ^ j[7:0]);
    end
    asleep = 1'b1;
    run_op(1'b1, 1'b1, 1'b1, 1'b0, 8'hc3);
    asleep = 1'b0;
    chk(IO_DATA, 8'h3d);
    $display("test receive done");
    wr(IO_DATA, 8'hff);
    run_op(1'b0, 1'b0, 1'b1, 1'b0, 8'hfe);
    chk(IO_STATUS, {ST_ARB_LOST, 3'h0});
    chk(IO_DATA, 8'hfe);
    $display("test arbitration done");
    final_report();
  end
  // generous: all tests need under 4000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end
endmodule // twsd_top_tb
